// ---- fr_mgr.sv ----
// Fault reaction manager: failure flags, fault pin, FET shutdown masks, shutdown register, self-test grant.
// Function
// - Error flag is OR of all failures set to error, auto restart or latched.
// - Error flag clears only after failure gone and error register read.
// - Fault pin goes low on any error-class failure.
// - Error and auto restart release the pin after failure gone and extension expired.
// - Latched failures hold the pin low until reset through the drive permit pin.
// - Shutdowns have fixed reactions, turning FETs off except flying cap overvoltage, and show in a shutdown register.
// - Shutdown bits: 7 overtemp, 4 bootstrap uv, 3 clock, 2 pump ov, 1 pump input, 0 path.
// - Clock trip reacts as auto restart or latched, pumps kept, pin low.
// - Pump overvolt: bootstrap node latches all off; flying cap latches second pump only.
// - Overtemp and pump input overload latch stages and pumps off, pin low.
// - Drive path violation latches stages off, pin low, pumps stay active.
// - Two-bit code: warning, error, auto restart all off, latched all off.
// - Short circuit code adds latch of half bridge and latch of one FET.
// - Buffer capacitor undervoltage codes 10 and 11 switch off only that high side.
// - Drain sense overvoltage adds auto restart and latch of all high sides.
// - Digital output overload: 0 error, 1 latched all off.
// - All failures are handled independently with no priority.
// - Self-tests run only in self-test mode, entered by dedicated commands.
// - Self-test requests are ranked with priority 1 highest.
// - Warning flag is OR of warnings, cleared after failure gone and register read.
// - Fault pin ignores failures until normal operation mode.
`timescale 1ns/1ps
module fr_mgr #(
   parameter int N_STD      = 4,
   parameter int N_ST       = 7,
   parameter int EXT_CYCLES = fr_pkg::EXT_CYCLES
) (
   input  wire logic               sys_clk,          // System clock, 10 MHz.
   input  wire logic               nrst,             // Asynchronous reset, active low.
   input  wire logic               config_mode,      // Configuration mode active.
   input  wire logic               normal_mode,      // Normal operation mode active.
   input  wire logic               selftest_mode,    // Self-test mode active.
   input  wire logic               drive_permit_pin, // Drive permit pin, low releases latches.
   input  wire logic               err_reg_read,     // Pulse: error register was read.
   input  wire logic [N_STD-1:0]   std_fail,         // Standard detections.
   input  wire logic [2*N_STD-1:0] std_code,         // Two-bit codes, two bits per detection.
   input  wire logic [5:0]         sc_fail,          // Short circuit per FET, bits 2:0 high side.
   input  wire logic [2:0]         sc_code,          // Short circuit behaviour code.
   input  wire logic [2:0]         hsuv_fail,        // Buffer capacitor undervoltage per high side.
   input  wire logic [1:0]         hsuv_code,        // Buffer capacitor undervoltage code.
   input  wire logic               highside_drain_sense_fail,        // Drain sense overvoltage.
   input  wire logic [2:0]         highside_drain_sense_code,        // Drain sense overvoltage code.
   input  wire logic               dout_fail,        // Digital output overload.
   input  wire logic               dout_code,        // Digital output overload code.
   input  wire fr_pkg::fr_trip_s   trips,            // Protective shutdown causes.
   input  wire logic [N_ST-1:0]    st_req,           // Self-test requests, bit 0 priority 1.
   output logic                    warning_flag,     // Warning status flag.
   output logic                    error_flag,       // Error status flag.
   output logic                    fault_pin_n,      // Fault pin, active low.
   output logic [5:0]              fet_off,          // FET off mask, bits 2:0 high side.
   output logic                    pumps_off,        // All charge pumps off.
   output logic                    second_pump_off,  // Second charge pump off.
   output logic [7:0]              shutdown_status,  // Shutdown register.
   output logic [N_ST-1:0]         st_grant          // Granted self-test, one-hot.
);
   localparam int N_CFG = N_STD + 11;
   localparam int N_ALL = N_CFG + 8;

   logic                 permit_meta_reg;
   logic                 permit_reg;
   logic [2*N_STD-1:0]   cfg_std_reg;
   logic [2:0]           cfg_sc_reg;
   logic [1:0]           cfg_hsuv_reg;
   logic [2:0]           cfg_highside_drain_sense_reg;
   logic                 cfg_dout_reg;
   fr_pkg::fr_react_s    react [N_ALL];
   logic                 warn_any;
   logic                 err_live;
   logic                 latch_set;
   logic [5:0]           off_now;
   logic [5:0]           off_latch;
   logic                 latch_reg;
   logic [5:0]           fet_latch_reg;
   logic                 pump_latch_reg;
   logic                 sp_latch_reg;
   logic [7:0]           sd_latch_reg;
   logic [7:0]           sd_live;
   logic [7:0]           sd_lset;
   logic                 release_now;
   logic                 ext_busy;
   logic [N_ST-1:0]      st_pick;

   // Drive permit pin is asynchronous and passes two flip-flops.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         permit_meta_reg <= 1'b0;
         permit_reg      <= 1'b0;
      end else begin
         permit_meta_reg <= drive_permit_pin;
         permit_reg      <= permit_meta_reg;
      end
   end
   assign release_now = !permit_reg;

   // Behaviour codes are taken only during configuration mode.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_std_reg  <= {N_STD{fr_pkg::DEF_STD}};
         cfg_sc_reg   <= fr_pkg::DEF_X;
         cfg_hsuv_reg <= fr_pkg::DEF_STD;
         cfg_highside_drain_sense_reg <= fr_pkg::DEF_X;
         cfg_dout_reg <= fr_pkg::DEF_DOUT;
      end else if (config_mode) begin
         cfg_std_reg  <= std_code;
         cfg_sc_reg   <= sc_code;
         cfg_hsuv_reg <= hsuv_code;
         cfg_highside_drain_sense_reg <= highside_drain_sense_code;
         cfg_dout_reg <= dout_code;
      end
   end

   // Each detection is decoded on its own; nothing ranks one against another.
   genvar g;
   generate
      for (g = 0; g < N_STD; g++) begin : g_std
         assign react[g] = fr_pkg::fr_std(std_fail[g], cfg_std_reg[2*g +: 2], fr_pkg::FET_ALL);
      end
      for (g = 0; g < 6; g++) begin : g_sc
         localparam logic [5:0] ONE = 6'h01 << g;
         localparam logic [5:0] HB  = (6'h09 << (g % 3));
         always_comb begin
            react[N_STD + g] = fr_pkg::fr_std(sc_fail[g], cfg_sc_reg[1:0], fr_pkg::FET_ALL);
            if (sc_fail[g] && cfg_sc_reg == fr_pkg::SC_LE_HB) begin
               react[N_STD + g] = fr_pkg::fr_std(1'b1, fr_pkg::BHV_LE, HB);
            end else if (sc_fail[g] && cfg_sc_reg == fr_pkg::SC_LE_ONE) begin
               react[N_STD + g] = fr_pkg::fr_std(1'b1, fr_pkg::BHV_LE, ONE);
            end
         end
      end
      for (g = 0; g < 3; g++) begin : g_hsuv
         localparam logic [5:0] HS1 = 6'h01 << g;
         assign react[N_STD + 6 + g] = fr_pkg::fr_std(hsuv_fail[g], cfg_hsuv_reg, HS1);
      end
   endgenerate

   always_comb begin
      react[N_STD + 9] = fr_pkg::fr_std(highside_drain_sense_fail, cfg_highside_drain_sense_reg[1:0], fr_pkg::FET_ALL);
      if (highside_drain_sense_fail && cfg_highside_drain_sense_reg == fr_pkg::VD_ARE_HS) begin
         react[N_STD + 9] = fr_pkg::fr_std(1'b1, fr_pkg::BHV_ARE, fr_pkg::FET_HS);
      end else if (highside_drain_sense_fail && cfg_highside_drain_sense_reg == fr_pkg::VD_LE_HS) begin
         react[N_STD + 9] = fr_pkg::fr_std(1'b1, fr_pkg::BHV_LE, fr_pkg::FET_HS);
      end
   end

   assign react[N_STD + 10] = fr_pkg::fr_std(dout_fail, {cfg_dout_reg, 1'b1}, fr_pkg::FET_ALL);

   // Shutdowns carry fixed reactions.
   assign react[N_CFG + 0] = fr_pkg::fr_std(trips.overtemp, fr_pkg::BHV_LE, fr_pkg::FET_ALL);
   assign react[N_CFG + 1] = fr_pkg::fr_std(trips.boot_uv, fr_pkg::BHV_ARE, fr_pkg::FET_ALL);
   assign react[N_CFG + 2] = fr_pkg::fr_std(trips.clk_are, fr_pkg::BHV_ARE, fr_pkg::FET_ALL);
   assign react[N_CFG + 3] = fr_pkg::fr_std(trips.clk_le, fr_pkg::BHV_LE, fr_pkg::FET_ALL);
   assign react[N_CFG + 4] = fr_pkg::fr_std(trips.ov_cb, fr_pkg::BHV_LE, fr_pkg::FET_ALL);
   assign react[N_CFG + 5] = fr_pkg::fr_std(trips.ov_flycap, fr_pkg::BHV_LE, fr_pkg::FET_NONE);
   assign react[N_CFG + 6] = fr_pkg::fr_std(trips.pump_in, fr_pkg::BHV_LE, fr_pkg::FET_ALL);
   assign react[N_CFG + 7] = fr_pkg::fr_std(trips.drive_path, fr_pkg::BHV_LE, fr_pkg::FET_ALL);

   always_comb begin
      warn_any  = 1'b0;
      err_live  = 1'b0;
      latch_set = 1'b0;
      off_now   = '0;
      off_latch = '0;
      for (int i = 0; i < N_ALL; i++) begin
         warn_any  = warn_any | react[i].warn;
         err_live  = err_live | (react[i].err & ~react[i].latch);
         latch_set = latch_set | react[i].latch;
         off_now   = off_now | (react[i].latch ? fr_pkg::FET_NONE : react[i].off);
         off_latch = off_latch | (react[i].latch ? react[i].off : fr_pkg::FET_NONE);
      end
   end

   assign sd_live[fr_pkg::OVERTEMP_TRIP]  = trips.overtemp;
   assign sd_live[6:5]            = 2'h0;
   assign sd_live[fr_pkg::SD_BUV] = trips.boot_uv;
   assign sd_live[fr_pkg::SD_CLK] = trips.clk_are | trips.clk_le;
   assign sd_live[fr_pkg::SD_POV] = trips.ov_cb | trips.ov_flycap;
   assign sd_live[fr_pkg::SD_PIN] = trips.pump_in;
   assign sd_live[fr_pkg::SD_DPV] = trips.drive_path;
   assign sd_lset                 = sd_live & {1'b1, 2'b00, 1'b0, trips.clk_le, 3'b111};

   // Latched reactions: a new latch in the release cycle wins over the release.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         latch_reg      <= 1'b0;
         fet_latch_reg  <= '0;
         pump_latch_reg <= 1'b0;
         sp_latch_reg   <= 1'b0;
         sd_latch_reg   <= fr_pkg::SD_RESET;
      end else begin
         latch_reg      <= (latch_reg & ~release_now) | latch_set;
         fet_latch_reg  <= (fet_latch_reg & ~{6{release_now}}) | off_latch;
         pump_latch_reg <= (pump_latch_reg & ~release_now)
                           | trips.overtemp | trips.ov_cb | trips.pump_in;
         sp_latch_reg   <= (sp_latch_reg & ~release_now) | trips.ov_flycap;
         sd_latch_reg   <= (sd_latch_reg & ~{8{release_now}}) | sd_lset;
      end
   end

   // Outputs toward the stages and pumps.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         fet_off         <= '0;
         pumps_off       <= 1'b0;
         second_pump_off <= 1'b0;
         shutdown_status <= fr_pkg::SD_RESET;
      end else begin
         fet_off         <= off_now | off_latch | (fet_latch_reg & ~{6{release_now}});
         pumps_off       <= pump_latch_reg | trips.overtemp | trips.ov_cb | trips.pump_in;
         second_pump_off <= pump_latch_reg | sp_latch_reg | trips.overtemp | trips.ov_cb
                            | trips.pump_in | trips.ov_flycap;
         shutdown_status <= sd_live | sd_latch_reg;
      end
   end

   // Status flags are sticky; a read clears them only once the cause is gone.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         error_flag   <= 1'b0;
         warning_flag <= 1'b0;
      end else begin
         error_flag   <= err_live | latch_set | latch_reg | (error_flag & ~err_reg_read);
         warning_flag <= warn_any | (warning_flag & ~err_reg_read);
      end
   end

   fr_ext_timer #(
      .CYCLES (EXT_CYCLES)
   ) u_ext (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .hold    (err_live),
      .busy    (ext_busy)
   );

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         fault_pin_n <= 1'b1;
      end else begin
         fault_pin_n <= !(normal_mode && (ext_busy || latch_set || latch_reg));
      end
   end

   // Lowest request index is priority 1.
   always_comb begin
      st_pick = '0;
      for (int i = N_ST - 1; i >= 0; i--) begin
         if (st_req[i]) begin
            st_pick = '0;
            st_pick[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_grant <= '0;
      end else begin
         st_grant <= selftest_mode ? st_pick : '0;
      end
   end

   // Cycles since the last non-latched failure, saturating at the extension length; used only by the checks below.
   localparam int            GW      = $clog2(EXT_CYCLES + 1);
   localparam logic [GW-1:0] GAP_END = GW'(EXT_CYCLES);
   logic [GW-1:0]            gap_reg;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         gap_reg <= GAP_END;
      end else if (err_live) begin
         gap_reg <= '0;
      end else if (gap_reg != GAP_END) begin
         gap_reg <= gap_reg + GW'(1);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   property p_err_set;
      err_live |=> error_flag;
   endproperty
   a_err_set: assert property (p_err_set) else $error("error flag not set");

   property p_err_hold;
      (error_flag && !err_reg_read) |=> error_flag;
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error flag cleared without read");

   property p_pin_low;
      (normal_mode && err_live) |=> !fault_pin_n;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("fault pin not low");

   property p_pin_ext;
      (normal_mode && !err_live && gap_reg != GAP_END) |=> !fault_pin_n;
   endproperty
   a_pin_ext: assert property (p_pin_ext) else $error("fault pin released before extension");

   property p_pin_rel;
      (normal_mode && !err_live && gap_reg == GAP_END && !latch_set && !latch_reg) |=> fault_pin_n;
   endproperty
   a_pin_rel: assert property (p_pin_rel) else $error("fault pin not released after extension");

   property p_latch_hold;
      (latch_reg && permit_reg && normal_mode) |=> (latch_reg && !fault_pin_n);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latched fault released early");

   property p_ot;
      trips.overtemp |=> (fet_off == fr_pkg::FET_ALL && pumps_off && shutdown_status[fr_pkg::OVERTEMP_TRIP]);
   endproperty
   a_ot: assert property (p_ot) else $error("overtemp reaction missing");

   property p_dpv;
      (trips.drive_path && !(trips.overtemp | trips.ov_cb | trips.pump_in) && !pump_latch_reg)
         |=> (fet_off == fr_pkg::FET_ALL && !pumps_off);
   endproperty
   a_dpv: assert property (p_dpv) else $error("drive path reaction wrong");

   property p_warn;
      warn_any |=> warning_flag;
   endproperty
   a_warn: assert property (p_warn) else $error("warning flag not set");

   property p_norm;
      !normal_mode |=> fault_pin_n;
   endproperty
   a_norm: assert property (p_norm) else $error("fault pin active outside normal mode");

   property p_grant;
      (!selftest_mode |=> st_grant == '0) and ($onehot0(st_grant));
   endproperty
   a_grant: assert property (p_grant) else $error("self-test grant wrong");

   property p_rel;
      (!permit_reg && !latch_set) |=> !latch_reg;
   endproperty
   a_rel: assert property (p_rel) else $error("latched reaction not released");

   property p_pri;
      (selftest_mode && st_req[0]) |=> st_grant[0];
   endproperty
   a_pri: assert property (p_pri) else $error("priority one self-test not granted");

   property p_flycap;
      (trips.ov_flycap && !(trips.overtemp | trips.ov_cb | trips.pump_in) && !pump_latch_reg)
         |=> (second_pump_off && !pumps_off);
   endproperty
   a_flycap: assert property (p_flycap) else $error("flying cap overvoltage reaction wrong");
endmodule

// ---- fr_pkg.sv ----
// Package with constants, carrier types and behaviour decoders of the fault reaction manager.
package fr_pkg;
   localparam int             N_FET         = 6;
   localparam logic [5:0]     FET_ALL       = 6'h3F;
   localparam logic [5:0]     FET_HS        = 6'h07;
   localparam logic [5:0]     FET_NONE      = 6'h00;
   localparam logic [1:0]     BHV_WARN      = 2'h0;
   localparam logic [1:0]     BHV_ERR       = 2'h1;
   localparam logic [1:0]     BHV_ARE       = 2'h2;
   localparam logic [1:0]     BHV_LE        = 2'h3;
   localparam logic [2:0]     SC_LE_HB      = 3'h6;
   localparam logic [2:0]     SC_LE_ONE     = 3'h7;
   localparam logic [2:0]     VD_ARE_HS     = 3'h6;
   localparam logic [2:0]     VD_LE_HS      = 3'h7;
   localparam logic [1:0]     DEF_STD       = 2'h1;
   localparam logic [2:0]     DEF_X         = 3'h1;
   localparam logic           DEF_DOUT      = 1'b0;
   localparam int             OVERTEMP_TRIP         = 7;
   localparam int             SD_BUV        = 4;
   localparam int             SD_CLK        = 3;
   localparam int             SD_POV        = 2;
   localparam int             SD_PIN        = 1;
   localparam int             SD_DPV        = 0;
   localparam logic [7:0]     SD_RESET      = 8'h00;
   localparam int             CLK_PERIOD_NS = 100;
   localparam int             EXT_TIME_NS   = 1000;
   localparam int             EXT_CYCLES    = (EXT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic       warn;
      logic       err;
      logic       latch;
      logic [5:0] off;
   } fr_react_s;

   typedef struct packed {
      logic overtemp;
      logic boot_uv;
      logic clk_are;
      logic clk_le;
      logic ov_cb;
      logic ov_flycap;
      logic pump_in;
      logic drive_path;
   } fr_trip_s;

   function automatic fr_react_s fr_std(input logic fail, input logic [1:0] code, input logic [5:0] mask);
      fr_react_s r;
      r = '0;
      if (fail) begin
         case (code)
            BHV_WARN: r.warn = 1'b1;
            BHV_ERR:  r.err = 1'b1;
            BHV_ARE: begin
               r.err = 1'b1;
               r.off = mask;
            end
            default: begin
               r.err   = 1'b1;
               r.latch = 1'b1;
               r.off   = mask;
            end
         endcase
      end
      return r;
   endfunction
endpackage

// ---- fr_ext_timer.sv ----
// Failure extension timer that holds the fault pin low after a non-latched failure clears.
`timescale 1ns/1ps
module fr_ext_timer #(
   parameter int CYCLES = fr_pkg::EXT_CYCLES
) (
   input  wire logic sys_clk,   // System clock.
   input  wire logic nrst,      // Asynchronous reset, active low.
   input  wire logic hold,      // Non-latched failure present.
   output logic      busy       // Extension still running.
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LOAD = W'(CYCLES);

   logic [W-1:0] cnt_reg;

   // The count reloads on every cycle of the failure, so it restarts when the failure ends.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
      end else if (hold) begin
         cnt_reg <= LOAD;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - W'(1);
      end
   end

   assign busy = hold || (cnt_reg != '0);
endmodule

// ---- fr_host.sv ----
// Controller model: behaviour codes, mode lines, register reads and the drive permit pin.
`timescale 1ns/1ps
module fr_host (
   input  wire logic  sys_clk,          // System clock.
   output logic       config_mode,      // Configuration mode.
   output logic       normal_mode,      // Normal operation mode.
   output logic       selftest_mode,    // Self-test mode.
   output logic       drive_permit_pin, // Low releases latched reactions.
   output logic       err_reg_read,     // Error register read pulse.
   output logic [7:0] std_code,         // Standard detection codes.
   output logic [2:0] sc_code,          // Short circuit code.
   output logic [1:0] hsuv_code,        // Buffer capacitor undervoltage code.
   output logic [2:0] highside_drain_sense_code,        // Drain sense overvoltage code.
   output logic       dout_code,        // Digital output overload code.
   output logic [6:0] st_req            // Self-test requests.
);
   initial begin
      {config_mode, normal_mode, selftest_mode, err_reg_read} = 4'h0;
      drive_permit_pin = 1'b1;
      {std_code, sc_code, hsuv_code, highside_drain_sense_code, dout_code, st_req} = '0;
   end
   // Codes change only inside configuration mode; normal mode follows it.
   task automatic cfg(input logic [2:0] c);
      @(posedge sys_clk);
      {config_mode, normal_mode} <= 2'h2;
      std_code  <= {4{c[1:0]}};
      sc_code   <= (c == 3'h2) ? 3'h1 : c;
      hsuv_code <= c[1:0];
      highside_drain_sense_code <= c;
      dout_code <= c[0];
      @(posedge sys_clk);
      {config_mode, normal_mode} <= 2'h1;
   endtask
   task automatic mode(input logic n, input logic s);
      @(posedge sys_clk);
      normal_mode   <= n;
      selftest_mode <= s;
   endtask
   task automatic rd;
      @(posedge sys_clk);
      err_reg_read <= 1'b1;
      @(posedge sys_clk);
      err_reg_read <= 1'b0;
   endtask
   // The pin is held low well past the two-stage synchroniser before it returns high.
   task automatic permit;
      @(posedge sys_clk);
      drive_permit_pin <= 1'b0;
      repeat (5) @(posedge sys_clk);
      drive_permit_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask
   // Callers pass a single bit except when ranking of requests is exercised and when the grant is checked outside self-test mode.
   task automatic st(input logic [6:0] m);
      @(posedge sys_clk);
      st_req <= m;
   endtask
endmodule

// ---- fr_mgr_bench.sv ----
// Self-checking bench of the fault reaction manager.
`timescale 1ns/1ps
module fr_mgr_bench;
   localparam int         EXT = 3;
   localparam logic [5:0] RUNS [15] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h0E, 6'h0F, 6'h0B, 6'h0D,
                                        6'h12, 6'h13, 6'h1E, 6'h1F, 6'h1A, 6'h20, 6'h21};
   localparam int         SB [8] = '{fr_pkg::SD_DPV, fr_pkg::SD_PIN, fr_pkg::SD_POV, fr_pkg::SD_POV,
                                     fr_pkg::SD_CLK, fr_pkg::SD_CLK, fr_pkg::SD_BUV, fr_pkg::OVERTEMP_TRIP};
   localparam logic [7:0] FOF = 8'hFB;
   localparam logic [7:0] PMP = 8'h8A;
   localparam logic [7:0] LAT = 8'h9F;
   logic             sys_clk, nrst, config_mode, normal_mode, selftest_mode, drive_permit_pin;
   logic             err_reg_read, highside_drain_sense_fail, dout_fail, dout_code, warning_flag, error_flag;
   logic             fault_pin_n, pumps_off, second_pump_off;
   logic [7:0]       std_code, shutdown_status;
   logic [3:0]       std_fail;
   logic [5:0]       sc_fail, fet_off;
   logic [2:0]       sc_code, hsuv_fail, highside_drain_sense_code;
   logic [1:0]       hsuv_code;
   logic [6:0]       st_req, st_grant;
   logic [8:0]       obs;
   fr_pkg::fr_trip_s trips;
   int               n_fail, check_count, seed;

   assign obs = {warning_flag, error_flag, fault_pin_n, fet_off};

   fr_host u_host (.sys_clk, .config_mode, .normal_mode, .selftest_mode, .drive_permit_pin, .err_reg_read,
                   .std_code, .sc_code, .hsuv_code, .highside_drain_sense_code, .dout_code, .st_req);
   fr_mgr #(.N_STD(4), .N_ST(7), .EXT_CYCLES(EXT)) u_dut (.sys_clk, .nrst, .config_mode, .normal_mode,
      .selftest_mode, .drive_permit_pin, .err_reg_read, .std_fail, .std_code, .sc_fail, .sc_code, .hsuv_fail,
      .hsuv_code, .highside_drain_sense_fail, .highside_drain_sense_code, .dout_fail, .dout_code, .trips, .st_req, .warning_flag, .error_flag,
      .fault_pin_n, .fet_off, .pumps_off, .second_pump_off, .shutdown_status, .st_grant);

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic go(input int n);
      repeat (n) @(posedge sys_clk);
      #10;
   endtask
   task automatic clean;
      u_host.permit;
      u_host.rd;
      go(EXT + 2);
      chk(obs, 9'h040);
   endtask
   function automatic logic [5:0] eoff(input int s, input logic [2:0] c, input int i);
      case (s)
         1: return c == 3'h7 ? 6'h01 << i : c == 3'h6 ? 6'h09 << (i % 3) : c[1] ? 6'h3F : 6'h00;
         2: return c[1] ? 6'h01 << i : 6'h00;
         3: return c[2] && c[1] ? 6'h07 : c[1] ? 6'h3F : 6'h00;
         4: return c[0] ? 6'h3F : 6'h00;
         default: return c[1] ? 6'h3F : 6'h00;
      endcase
   endfunction
   task automatic run(input int s, input logic [2:0] c);
      int i;
      logic [5:0] eo;
      logic l, w;
      i = $unsigned($random(seed)) % (s == 1 ? 6 : s == 2 ? 3 : s == 0 ? 4 : 1);
      eo = eoff(s, c, i);
      l = (c == 3'h3) || (s == 1 && c >= 3'h6) || (s == 3 && c == 3'h7) || (s == 4 && c[0]);
      w = s != 4 && c[1:0] == 2'h0;
      u_host.cfg(c);
      @(posedge sys_clk);
      case (s)
         0: std_fail <= 4'h1 << i;
         1: sc_fail <= 6'h01 << i;
         2: hsuv_fail <= 3'h1 << i;
         3: highside_drain_sense_fail <= 1'b1;
         default: dout_fail <= 1'b1;
      endcase
      go(1);
      chk(obs, {w, !w, w, eo});
      u_host.rd;
      go(0);
      chk(obs, {w, !w, w, eo});
      @(posedge sys_clk);
      {std_fail, sc_fail, hsuv_fail, highside_drain_sense_fail, dout_fail} <= '0;
      go(EXT);
      chk(obs, {w, !w, w, l ? eo : 6'h00});
      go(3);
      chk(obs, {w, !w, !l, l ? eo : 6'h00});
      clean;
      $display("reaction test source %0d code %0d done", s, c);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      int k;
      logic [6:0] r;
      n_fail = 0;
      check_count = 0;
      seed = 61945;
      nrst = 1'b0;
      {std_fail, sc_fail, hsuv_fail, highside_drain_sense_fail, dout_fail} = '0;
      trips = '0;
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      foreach (RUNS[j]) run(int'(RUNS[j][5:3]), RUNS[j][2:0]);
      for (k = 0; k < 8; k++) begin
         @(posedge sys_clk);
         trips <= fr_pkg::fr_trip_s'(8'h01 << k);
         go(1);
         chk(9'(shutdown_status), 9'(8'h01 << SB[k]));
         chk(obs, {2'h1, 1'b0, FOF[k] ? 6'h3F : 6'h00});
         chk(9'({pumps_off, ~PMP[k] & second_pump_off}), 9'({PMP[k], k == 2}));
         @(posedge sys_clk);
         trips <= '0;
         go(EXT + 3);
         chk(obs, {2'h1, !LAT[k], LAT[k] && FOF[k] ? 6'h3F : 6'h00});
         clean;
         chk(9'(shutdown_status), 9'h000);
      end
      $display("shutdown test done");
      u_host.cfg(3'h0);
      @(posedge sys_clk);
      std_fail <= 4'h8;
      trips <= fr_pkg::fr_trip_s'(8'h01);
      go(1);
      chk(obs, 9'h1BF);
      @(posedge sys_clk);
      std_fail <= '0;
      trips <= '0;
      clean;
      u_host.cfg(3'h1);
      u_host.mode(1'b0, 1'b0);
      @(posedge sys_clk);
      std_fail <= 4'h1;
      go(1);
      chk(obs, 9'h0C0);
      @(posedge sys_clk);
      std_fail <= '0;
      u_host.mode(1'b1, 1'b0);
      clean;
      $display("concurrency and mode test done");
      u_host.mode(1'b0, 1'b1);
      for (k = 0; k < 16; k++) begin
         r = k < 7 ? 7'h01 << k : 7'($random(seed));
         u_host.st(r);
         go(1);
         chk(9'(st_grant), 9'(r & (~r + 7'h01)));
      end
      u_host.st(7'h7F);
      u_host.mode(1'b1, 1'b0);
      go(1);
      chk(9'(st_grant), 9'h000);
      $display("self-test grant test done");
      results;
   end
endmodule
